//--- bsc_dead_time.sv
`timescale 1ns/100ps
module bsc_dead_time (
  input  logic        pclk,
  input  logic        presetn,
  bsc_phase_if.stage  ph
);
  logic       hi_q;
  logic       lo_q;
  logic [3:0] off_cnt_q;
  logic [3:0] off_cnt_d;

  wire both_off = !hi_q && !lo_q;
  // A side may switch on only after the pair has been dark long enough
  wire gap_done = both_off && (off_cnt_q == bsc_pkg::DEAD_CNT_LAST);
  wire hi_d     = ph.hi_req && !ph.lo_req && (hi_q || gap_done);
  wire lo_d     = ph.lo_req && !ph.hi_req && (lo_q || gap_done);

  assign off_cnt_d = !both_off ? 4'h0 :
                     (off_cnt_q == bsc_pkg::DEAD_CNT_LAST) ? off_cnt_q : off_cnt_q + 4'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q      <= 1'b0;
      lo_q      <= 1'b0;
      off_cnt_q <= 4'h0;
    end else begin
      hi_q      <= hi_d;
      lo_q      <= lo_d;
      off_cnt_q <= off_cnt_d;
    end
  end

  assign ph.hi_gate = hi_q;
  assign ph.lo_gate = lo_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_no_overlap: assert property (!(hi_q && lo_q))
    else $error("high and low gate on together");
  a_dead_hi_lo: assert property ($fell(hi_q) |-> ##1 !lo_q [*8])
    else $error("low gate on inside dead time");
  a_dead_lo_hi: assert property ($fell(lo_q) |-> ##1 !hi_q [*8])
    else $error("high gate on inside dead time");
endmodule // bsc_dead_time

//--- bsc_hall_model.sv
`timescale 1ns/100ps
module bsc_hall_model (
  input  wire logic        pclk,
  input  wire logic        run,
  input  wire logic        rev,
  input  wire logic [15:0] step_cyc,
  input  wire logic        bad_en,
  input  wire logic [2:0]  bad_code,
  output logic             hall_a,
  output logic             hall_b,
  output logic             hall_c
);
  logic [2:0]  seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  logic [2:0]  idx_q = 3'h0;
  logic [15:0] cnt_q = 16'h0;
  // One sector lasts step_cyc + 1 clocks
  always @(posedge pclk) begin
    cnt_q <= (run && cnt_q < step_cyc) ? cnt_q + 16'h1 : 16'h0;
    if (run && cnt_q >= step_cyc) begin
      idx_q <= rev ? (idx_q == 3'h0 ? 3'h5 : idx_q - 3'h1)
                   : (idx_q == 3'h5 ? 3'h0 : idx_q + 3'h1);
    end
  end
  // Illegal codes only on command
  assign {hall_c, hall_b, hall_a} = bad_en ? bad_code : seq[idx_q];
endmodule // bsc_hall_model

//--- bsc_phase_if.sv
`timescale 1ns/100ps
interface bsc_phase_if;
  logic hi_req;
  logic lo_req;
  logic hi_gate;
  logic lo_gate;
  modport ctrl  (output hi_req, output lo_req, input hi_gate, input lo_gate);
  modport stage (input hi_req, input lo_req, output hi_gate, output lo_gate);
endinterface

//--- bsc_pkg.sv
package bsc_pkg;
  // Register map, byte addresses
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STAT   = 12'h004;
  localparam logic [11:0] REG_PERIOD = 12'h008;
  // Control fields; reset leaves speed at zero and pulse select high
  localparam int          CTL_SPEED_LSB = 0;
  localparam int          CTL_LEAD_LSB  = 8;
  localparam int          CTL_DIR_BIT   = 14;
  localparam int          CTL_PCS_BIT   = 15;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_8000;
  // Speed command codes, full scale 8'hff
  localparam logic [7:0]  SPD_OFF_MAX     = 8'h1a;
  localparam logic [7:0]  SPD_REFRESH_MAX = 8'h36;
  localparam logic [7:0]  SPD_TEST_MIN    = 8'hd1;
  localparam logic [7:0]  SPD_SAT         = 8'h8a;
  // Carrier and gate timing in reference clocks
  localparam int          CARRIER_DIV  = 252;
  localparam int          REFRESH_PCT  = 8;
  localparam int          DUTY_MAX_PCT = 92;
  localparam logic [7:0]  CARRIER_LAST = 8'(CARRIER_DIV - 1);
  localparam logic [7:0]  CARRIER_HALF = 8'(CARRIER_DIV / 2);
  localparam logic [7:0]  REFRESH_CYC  = 8'(CARRIER_DIV * REFRESH_PCT / 100);
  localparam logic [7:0]  DUTY_MAX_LVL = 8'(CARRIER_DIV / 2 * DUTY_MAX_PCT / 100);
  localparam int          DEAD_CYC     = 9;
  localparam logic [3:0]  DEAD_CNT_LAST = 4'(DEAD_CYC - 1);
  // Position modulation
  localparam logic [4:0]  LEAD_MAX     = 5'h1f;
  localparam int          ANGLE_STEPS  = 192;
  // Rotation rate thresholds as 60-degree intervals in clocks
  localparam int          SINE_RATE_DIV = 750000;
  localparam int          REV_RATE_DIV  = 150000;
  // Restraint timer ticks
  localparam logic [11:0] RS_DRIVE_LAST = 12'(500 - 1);
  localparam logic [11:0] RS_HALT_LAST  = 12'(3000 - 1);

  typedef enum logic [1:0] {RGN_OFF, RGN_REFRESH, RGN_NORMAL, RGN_TEST} bsc_region_type;
  typedef enum logic [1:0] {RS_IDLE, RS_DRIVE, RS_HALT} bsc_rs_state_type;
endpackage

//--- bsc_top.sv
`timescale 1ns/100ps
// Behaviour
// - Square 120-degree drive until 60-degree interval drops below threshold
// - Faster than threshold: 180-degree sine PWM against triangle carrier
// - Lowest speed region blocks all six gates
// - Refresh region: low sides only, once per carrier, 8 percent
// - Normal region: sine direct; square adds low-side refresh pulse
// - Test region: sine with zero lead, square on upwind
// - Duty clamps to 92 percent of carrier at saturation code
// - Nine clock dead time between sides of a phase
// - Lead angle in 1.875 degree steps, saturating at step 31
// - Triangle carrier is clock divided by 252, also times refresh
// - Pulse out follows hall a, or toggles on every hall edge
// - Overcurrent blocks gates until next carrier period start
// - Fault input low blocks gates until next carrier after high
// - All-high or all-low hall code blocks gates
// - Sine drive keeps prior position on unexpected hall code
// - Supply out of range puts all gates in high impedance
// - Restraint repeats drive and halt in ratio 1 to 6
// - Restraint counts above refresh, below 1 Hz or 5 Hz reversed
// - Halt period holds gates low, no refresh pulses
// - Low speed resets counter in drive, not during halt
// - Drive 500 timer ticks, halt 3000 timer ticks
// - Timer pin open blocks gates; grounded disables protection
// - Each sector is 32 ticks of previous interval over 32
// - Reverse rotation drives square with zero lead
module bsc_top #(
  parameter int SINE_THRESH_CYC = bsc_pkg::SINE_RATE_DIV,
  parameter int REV_THRESH_CYC  = bsc_pkg::REV_RATE_DIV
) (
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [11:0] paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        hall_a,
  input  logic        hall_b,
  input  logic        hall_c,
  input  logic        fault_shutdown_input,
  input  logic        overcurrent_flag,
  input  logic        supply_ok,
  input  logic        restraint_timer_pin,
  input  logic        restraint_pin_open,
  input  logic        restraint_pin_grounded,
  output logic [2:0]  gate_hi,
  output logic [2:0]  gate_lo,
  output logic        gate_oe_n,
  output logic        rotation_pulse_out
);
  function automatic logic [2:0] sector_of(input logic [2:0] h);
    case (h)
      3'b001:  sector_of = 3'd0;
      3'b011:  sector_of = 3'd1;
      3'b010:  sector_of = 3'd2;
      3'b110:  sector_of = 3'd3;
      3'b100:  sector_of = 3'd4;
      3'b101:  sector_of = 3'd5;
      default: sector_of = 3'd7;
    endcase
  endfunction

  function automatic logic [2:0] step6(input logic [2:0] s, input logic [2:0] n);
    logic [3:0] t;
    t = {1'b0, s} + {1'b0, n};
    step6 = (t >= 4'd6) ? 3'(t - 4'd6) : t[2:0];
  endfunction

  function automatic logic [7:0] wrap192(input logic [9:0] v);
    logic [9:0] t;
    t = v;
    for (int i = 0; i < 4; i++) begin
      if (t >= 10'(bsc_pkg::ANGLE_STEPS)) t = t - 10'(bsc_pkg::ANGLE_STEPS);
    end
    wrap192 = t[7:0];
  endfunction

  // Synchronisers for every pin-level input
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {restraint_pin_grounded, restraint_pin_open, restraint_timer_pin,
                  supply_ok, overcurrent_flag, fault_shutdown_input,
                  hall_c, hall_b, hall_a};
      sync2_q <= sync1_q;
    end
  end
  wire [2:0] hall_s = sync2_q[2:0];
  wire       fault_ok_s = sync2_q[3];
  wire       oc_s = sync2_q[4];
  wire       supply_s = sync2_q[5];
  wire       tr_s = sync2_q[6];
  wire       tr_open_s = sync2_q[7];
  wire       tr_gnd_s = sync2_q[8];

  // APB slave, zero wait states
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  wire         addr_ok = (paddr == bsc_pkg::REG_CTRL) || (paddr == bsc_pkg::REG_STAT) ||
                         (paddr == bsc_pkg::REG_PERIOD);
  wire         wr_ctrl = psel && penable && pwrite && (paddr == bsc_pkg::REG_CTRL);
  wire [7:0]   spd = ctrl_q[bsc_pkg::CTL_SPEED_LSB +: 8];
  wire [5:0]   lead_in = ctrl_q[bsc_pkg::CTL_LEAD_LSB +: 6];
  wire         dir = ctrl_q[bsc_pkg::CTL_DIR_BIT];
  wire         pcs = ctrl_q[bsc_pkg::CTL_PCS_BIT];
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_q;

  // Carrier: one counter, triangle folded from it
  logic [7:0] pc_q;
  wire        carrier_end = (pc_q == bsc_pkg::CARRIER_LAST);
  wire [7:0]  tri_w = (pc_q < bsc_pkg::CARRIER_HALF) ? pc_q : bsc_pkg::CARRIER_LAST - pc_q;
  wire        ref_pulse = (pc_q < bsc_pkg::REFRESH_CYC);

  bsc_pkg::bsc_region_type rgn;
  assign rgn = (spd <= bsc_pkg::SPD_OFF_MAX)     ? bsc_pkg::RGN_OFF :
               (spd <= bsc_pkg::SPD_REFRESH_MAX) ? bsc_pkg::RGN_REFRESH :
               (spd >= bsc_pkg::SPD_TEST_MIN)    ? bsc_pkg::RGN_TEST : bsc_pkg::RGN_NORMAL;

  // Hall position tracking
  logic [2:0]  hall_q;
  logic [2:0]  sec_q;
  logic        rev_q;
  logic [23:0] since_q;
  logic [23:0] int_q;
  logic [18:0] tcnt_q;
  logic [4:0]  tick_q;
  logic        sine_q;
  logic        fg_q;
  wire  [2:0]  sec_raw = sector_of(hall_s);
  wire         hall_bad = (hall_s == 3'b000) || (hall_s == 3'b111);
  wire         fwd_step = (sec_raw == step6(sec_q, 3'd1));
  wire         rev_step = (sec_raw == step6(sec_q, 3'd5));
  // Sine drive ignores codes that are not one sector away
  wire         acc = !hall_bad && (sec_raw != sec_q) && (!sine_q || fwd_step || rev_step);
  wire         upwind = rev_q ^ dir;
  wire         slow = (since_q >= 24'(SINE_THRESH_CYC)) || (int_q >= 24'(SINE_THRESH_CYC));
  wire         rev_slow = (since_q >= 24'(REV_THRESH_CYC)) || (int_q >= 24'(REV_THRESH_CYC));
  wire         sine_d = !slow && !upwind && !hall_bad;
  wire [18:0]  tick_len = int_q[23:5];
  wire         tick_hit = (tcnt_q >= tick_len);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_q  <= 3'b000;
      sec_q   <= 3'd0;
      rev_q   <= 1'b0;
      since_q <= 24'h00_0000;
      int_q   <= 24'hff_ffff;
      tcnt_q  <= 19'h0_0000;
      tick_q  <= 5'h00;
      sine_q  <= 1'b0;
    end else begin
      hall_q <= hall_s;
      sine_q <= sine_d;
      if (acc) begin
        sec_q   <= sec_raw;
        int_q   <= since_q;
        since_q <= 24'h00_0000;
        tcnt_q  <= 19'h0_0000;
        tick_q  <= 5'h00;
        if (fwd_step || rev_step) rev_q <= rev_step;
      end else begin
        if (since_q != 24'hff_ffff) since_q <= since_q + 24'h00_0001;
        tcnt_q <= tick_hit ? 19'h0_0000 : tcnt_q + 19'h0_0001;
        // Ticks park at the sector end if the next edge is late
        if (tick_hit && tick_q != 5'h1f) tick_q <= tick_q + 5'h01;
      end
    end
  end

  // Rotation pulse
  wire fg_d = pcs ? (fg_q ^ (|(hall_s ^ hall_q))) : hall_s[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fg_q <= 1'b0;
    end else begin
      fg_q <= fg_d;
    end
  end
  assign rotation_pulse_out = fg_q;

  // Fault latches; a new event wins over the carrier release
  logic oc_blk_q;
  logic flt_blk_q;
  logic oe_n_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q      <= 8'h00;
      oc_blk_q  <= 1'b0;
      flt_blk_q <= 1'b1;
      oe_n_q    <= 1'b1;
    end else begin
      pc_q      <= carrier_end ? 8'h00 : pc_q + 8'h01;
      oc_blk_q  <= oc_s || (oc_blk_q && !carrier_end);
      flt_blk_q <= !fault_ok_s || (flt_blk_q && !carrier_end);
      oe_n_q    <= !supply_s;
    end
  end
  assign gate_oe_n = oe_n_q;

  // Restraint protection, timed by the external timer oscillator
  bsc_pkg::bsc_rs_state_type rs_q;
  logic [11:0] rs_cnt_q;
  logic        tr_q;
  wire         tr_tick = tr_s && !tr_q;
  wire         spd_run = (rgn == bsc_pkg::RGN_NORMAL) || (rgn == bsc_pkg::RGN_TEST);
  wire         stall = upwind ? rev_slow : slow;
  wire         halt = (rs_q == bsc_pkg::RS_HALT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_q     <= bsc_pkg::RS_IDLE;
      rs_cnt_q <= 12'h000;
      tr_q     <= 1'b0;
    end else begin
      tr_q <= tr_s;
      if (tr_gnd_s) begin
        rs_q     <= bsc_pkg::RS_IDLE;
        rs_cnt_q <= 12'h000;
      end else begin
        case (rs_q)
          bsc_pkg::RS_IDLE: begin
            rs_cnt_q <= 12'h000;
            if (spd_run) rs_q <= bsc_pkg::RS_DRIVE;
          end
          bsc_pkg::RS_DRIVE: begin
            if (!spd_run) begin
              rs_q     <= bsc_pkg::RS_IDLE;
              rs_cnt_q <= 12'h000;
            end else if (!stall) begin
              rs_cnt_q <= 12'h000;
            end else if (tr_tick) begin
              if (rs_cnt_q == bsc_pkg::RS_DRIVE_LAST) begin
                rs_q     <= bsc_pkg::RS_HALT;
                rs_cnt_q <= 12'h000;
              end else begin
                rs_cnt_q <= rs_cnt_q + 12'h001;
              end
            end
          end
          bsc_pkg::RS_HALT: begin
            if (tr_tick) begin
              if (rs_cnt_q == bsc_pkg::RS_HALT_LAST) begin
                rs_q     <= bsc_pkg::RS_DRIVE;
                rs_cnt_q <= 12'h000;
              end else begin
                rs_cnt_q <= rs_cnt_q + 12'h001;
              end
            end
          end
          default: begin
            rs_q     <= bsc_pkg::RS_IDLE;
            rs_cnt_q <= 12'h000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= bsc_pkg::CTRL_RESET;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl_q <= pwdata;
      if (psel && !penable) begin
        prdata_q <= (paddr == bsc_pkg::REG_CTRL)   ? ctrl_q :
                    (paddr == bsc_pkg::REG_STAT)   ? {19'h0, rgn, rs_q, sec_q, halt,
                                                      flt_blk_q, oc_blk_q, hall_bad,
                                                      upwind, sine_q} :
                    (paddr == bsc_pkg::REG_PERIOD) ? {8'h00, int_q} : 32'h0000_0000;
      end
    end
  end

  // Drive amplitude from speed, saturating at the clamp code
  wire [7:0] spd_c = (spd > bsc_pkg::SPD_SAT) ? bsc_pkg::SPD_SAT : spd;
  wire [6:0] amp = (spd_c > bsc_pkg::SPD_REFRESH_MAX) ?
                   7'(spd_c - bsc_pkg::SPD_REFRESH_MAX) : 7'h00;
  wire [6:0] amp8 = amp + {1'b0, amp[6:1]};
  wire [7:0] sq_lvl = ({1'b0, amp8} > bsc_pkg::DUTY_MAX_LVL) ? bsc_pkg::DUTY_MAX_LVL
                                                             : {1'b0, amp8};
  wire       lead_zero = (rgn == bsc_pkg::RGN_TEST) || upwind;
  wire [4:0] lead_sat = (lead_in > 6'(bsc_pkg::LEAD_MAX)) ? bsc_pkg::LEAD_MAX : lead_in[4:0];
  wire [4:0] lead_eff = lead_zero ? 5'h00 : lead_sat;
  wire [9:0] base = {2'b00, sec_q, 5'h00};
  // Reverse set direction walks the angle downward through each sector
  wire [9:0] pos = dir ? base + 10'd224 - {5'h00, tick_q} - {5'h00, lead_eff}
                       : base + {5'h00, tick_q} + {5'h00, lead_eff};
  wire [2:0] sq_sec = dir ? step6(sec_q, 3'd3) : sec_q;
  wire       kill = hall_bad || oc_blk_q || flt_blk_q || halt || tr_open_s ||
                    !supply_s || (rgn == bsc_pkg::RGN_OFF);

  logic [7:0] lvl_q [3];
  logic [2:0] hi_req_q;
  logic [2:0] lo_req_q;
  bsc_phase_if ph [3] ();

  for (genvar k = 0; k < 3; k++) begin : g_ph
    wire [7:0]  ang = wrap192(pos + 10'(384 - 64 * k));
    wire        neg = (ang >= 8'd96);
    wire [6:0]  h = neg ? 7'(ang - 8'd96) : ang[6:0];
    wire [13:0] p = {7'h00, h} * {7'h00, 7'd96 - h};
    wire [16:0] m = {3'b000, p} * 17'd7;
    wire [12:0] d = {7'h00, m[13:8]} * {6'h00, amp8};
    wire [7:0]  lvl = neg ? 8'd63 - {2'b00, d[12:7]} : 8'd63 + {2'b00, d[12:7]};
    wire [7:0]  lvl_c = (lvl > bsc_pkg::DUTY_MAX_LVL) ? bsc_pkg::DUTY_MAX_LVL : lvl;
    wire [2:0]  e = step6(sq_sec, 3'(6 - 2 * k));
    wire        sq_hi = (e < 3'd2);
    wire        sq_lo = (e == 3'd3) || (e == 3'd4);
    wire        sin_on = (lvl_q[k] > tri_w);
    wire        hi_d = kill ? 1'b0 :
                       (rgn == bsc_pkg::RGN_REFRESH) ? 1'b0 :
                       sine_q ? sin_on :
                       ref_pulse ? 1'b0 : sq_hi && (sq_lvl > tri_w);
    wire        lo_d = kill ? 1'b0 :
                       (rgn == bsc_pkg::RGN_REFRESH) ? ref_pulse :
                       sine_q ? !sin_on :
                       ref_pulse ? 1'b1 : sq_lo;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lvl_q[k]    <= 8'h00;
        hi_req_q[k] <= 1'b0;
        lo_req_q[k] <= 1'b0;
      end else begin
        lvl_q[k]    <= lvl_c;
        hi_req_q[k] <= hi_d;
        lo_req_q[k] <= lo_d;
      end
    end

    assign ph[k].hi_req = hi_req_q[k];
    assign ph[k].lo_req = lo_req_q[k];
    assign gate_hi[k]   = ph[k].hi_gate;
    assign gate_lo[k]   = ph[k].lo_gate;

    bsc_dead_time u_dead (
      .pclk    (pclk),
      .presetn (presetn),
      .ph      (ph[k])
    );
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_carrier_period: assert property ((pc_q == 8'h00) |-> ##252 (pc_q == 8'h00))
    else $error("carrier period is not 252 clocks");
  a_gate_block_off: assert property ($past(rgn == bsc_pkg::RGN_OFF, 2) |-> !(|{gate_hi, gate_lo}))
    else $error("gate on in lowest speed region");
  a_oc_kill: assert property ($past(oc_blk_q, 2) |-> !(|{gate_hi, gate_lo}))
    else $error("gate on under overcurrent block");
  a_oc_hold: assert property ((oc_blk_q && !carrier_end) |=> oc_blk_q)
    else $error("overcurrent block left before carrier end");
  // The fault pin reaches the gates through its latch, so watch the latch
  a_fault_kill: assert property ($past(flt_blk_q, 2) |-> !(|{gate_hi, gate_lo}))
    else $error("gate on while fault input low");
  a_bad_hall_kill: assert property ($past(hall_bad, 2) |-> !(|{gate_hi, gate_lo}))
    else $error("gate on with illegal hall code");
  a_halt_kill: assert property ($past(halt, 2) |-> !(|{gate_hi, gate_lo}))
    else $error("gate on during restraint halt");
  a_halt_length: assert property ((halt && tr_tick && rs_cnt_q == 12'd2999 && !tr_gnd_s)
                                  |=> rs_q == bsc_pkg::RS_DRIVE)
    else $error("halt period not 3000 ticks");
  a_pulse_follow: assert property ((!pcs && $past(!pcs)) |-> fg_q == $past(hall_s[0]))
    else $error("pulse out does not follow hall a");
  a_sine_thresh: assert property (sine_q |-> $past(int_q) < 24'(SINE_THRESH_CYC))
    else $error("sine drive below rate threshold");
  a_lead_sat: assert property ((lead_in > 6'd31 && !lead_zero) |-> lead_eff == 5'd31)
    else $error("lead angle not saturated");
endmodule // bsc_top

//--- testbench.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdata;
  logic pready, pslverr, rerr, oe_n, pulse, run = 1, rev = 0, bad_en = 0;
  logic ha, hb, hc, fault = 1, oc = 0, sup = 1, tpin = 0, topen = 0, tgnd = 1;
  logic [2:0] gate_hi, gate_lo, bad_code = 0;
  logic [15:0] step = 16'd399;
  int error_cnt = 0, cmp_count = 0, cyc = 0, tog = 0, dt_err = 0;
  int hi_n, lo_n, any, t1, t2, t3, hi_age[3] = '{99, 99, 99}, lo_age[3] = '{99, 99, 99};
  bsc_hall_model hall (.pclk(pclk), .run(run), .rev(rev), .step_cyc(step), .bad_en(bad_en),
    .bad_code(bad_code), .hall_a(ha), .hall_b(hb), .hall_c(hc));
  bsc_top #(.SINE_THRESH_CYC(2000), .REV_THRESH_CYC(10000)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hall_a(ha),
    .hall_b(hb), .hall_c(hc), .fault_shutdown_input(fault), .overcurrent_flag(oc),
    .supply_ok(sup), .restraint_timer_pin(tpin), .restraint_pin_open(topen),
    .restraint_pin_grounded(tgnd), .gate_hi(gate_hi), .gate_lo(gate_lo), .gate_oe_n(oe_n),
    .rotation_pulse_out(pulse));
  always #5 pclk = ~pclk;
  // Timer oscillator ticks every 4 clocks
  always @(posedge pclk) tpin <= tpin ^ cyc[0];
  logic pulse_q = 0;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    pulse_q <= pulse;
    if (pulse !== pulse_q) tog <= tog + 1;
    for (int i = 0; i < 3; i++) begin
      if (gate_hi[i] === 1'b1 && hi_age[i] > 0 && lo_age[i] < 9) dt_err++;
      if (gate_lo[i] === 1'b1 && lo_age[i] > 0 && hi_age[i] < 9) dt_err++;
      hi_age[i] = (gate_hi[i] === 1'b1) ? 0 : hi_age[i] + 1;
      lo_age[i] = (gate_lo[i] === 1'b1) ? 0 : lo_age[i] + 1;
    end
  end
  task automatic end_of_test();
    $display("Compares %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin error_cnt++; end_of_test(); end
    rdata = prdata; rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic ctrl(input logic [7:0] spd, input logic [5:0] lead, input logic pcs);
    apb(1, bsc_pkg::REG_CTRL, {16'h0, pcs, 1'b0, lead, spd});
  endtask
  task automatic watch(input int n);
    hi_n = 0; lo_n = 0; any = 0;
    repeat (n) @(posedge pclk) begin
      hi_n += (gate_hi[0] === 1'b1); lo_n += (gate_lo[0] === 1'b1);
      any += ((gate_hi | gate_lo) !== 3'h0);
    end
  endtask
  task automatic wait_rs(input logic [1:0] st, output int t);
    int n;
    n = 0;
    do begin apb(0, bsc_pkg::REG_STAT, 0); n++; end while (rdata[10:9] !== st && n < 5000);
    if (n >= 5000) begin error_cnt++; end_of_test(); end
    t = cyc;
  endtask
  logic [7:0] codes [6] = '{8'h1a, 8'h1b, 8'h36, 8'h37, 8'hd0, 8'hd1};
  logic [1:0] rgns [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  initial begin
    void'($urandom(19205));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, bsc_pkg::REG_CTRL, 0); `CHK("ctrl_reset", bsc_pkg::CTRL_RESET, rdata)
    apb(1, bsc_pkg::REG_STAT, 32'hffff_ffff); `CHK("stat_wr_err", 1'b0, rerr)
    apb(0, 12'h00c, 0); `CHK("bad_err", 1'b1, rerr)
    `CHK("bad_data", 32'h0, rdata)
    for (int i = 0; i < 6; i++) begin
      ctrl(codes[i], 0, 1); apb(0, bsc_pkg::REG_STAT, 0);
      `CHK("region", rgns[i], rdata[12:11])
    end
    ctrl(8'h10, 0, 1); repeat (300) @(posedge pclk); watch(252);
    `CHK("off_gates", 0, any)
    ctrl(8'h30, 0, 1); watch(30); watch(252);
    `CHK("refresh_hi", 0, hi_n)
    `CHK("refresh_lo", 252 * 8 / 100, lo_n)
    repeat (3) begin
      step <= 16'($urandom_range(200, 600));
      ctrl(8'($urandom_range(8'h37, 8'hd0)), 6'($urandom_range(0, 63)), 1);
      repeat (4000) @(posedge pclk); apb(0, bsc_pkg::REG_STAT, 0);
      `CHK("sine", 1'b1, rdata[0])
    end
    step <= 16'd2499; repeat (16000) @(posedge pclk); apb(0, bsc_pkg::REG_STAT, 0);
    `CHK("square", 1'b0, rdata[0])
    step <= 16'd399; rev <= 1; ctrl(8'he0, 0, 1); repeat (4000) @(posedge pclk);
    apb(0, bsc_pkg::REG_STAT, 0); `CHK("upwind", 2'h2, rdata[1:0])
    rev <= 0; ctrl(8'hff, 0, 1); repeat (4000) @(posedge pclk); watch(252);
    `CHK("duty_clamp", 1'b1, hi_n <= 232)
    for (int k = 0; k < 5; k++) begin
      fault <= (k != 0); oc <= (k == 1); topen <= (k == 2); bad_en <= (k > 2);
      bad_code <= (k == 4) ? 3'h7 : 3'h0;
      repeat (8) @(posedge pclk); watch(100);
      `CHK("kill", 0, any)
      fault <= 1; oc <= 0; topen <= 0; bad_en <= 0;
      repeat (600) @(posedge pclk); watch(252);
      `CHK("resume", 1'b1, any > 0)
    end
    sup <= 0; repeat (8) @(posedge pclk); `CHK("hiz", 1'b1, oe_n)
    sup <= 1; repeat (8) @(posedge pclk); `CHK("drive", 1'b0, oe_n)
    for (int p = 0; p < 2; p++) begin
      ctrl(8'h80, 0, p[0]); repeat (500) @(posedge pclk); t1 = tog;
      repeat (4800) @(posedge pclk); `CHK("pulses", p ? 12 : 4, tog - t1)
    end
    run <= 0; repeat (3000) @(posedge pclk); apb(0, bsc_pkg::REG_STAT, 0);
    `CHK("rs_gnd", 2'h0, rdata[10:9])
    tgnd <= 0; wait_rs(2'h1, t1); wait_rs(2'h2, t2);
    `CHK("rs_drive", 1'b1, (t2 - t1) > 1900 && (t2 - t1) < 2100)
    watch(300); `CHK("halt_gates", 0, any)
    // Drive after halt lasts one clock at refresh speed, so wait for idle
    ctrl(8'h30, 0, 1); wait_rs(2'h0, t3);
    `CHK("rs_halt", 1'b1, (t3 - t2) > 11800 && (t3 - t2) < 12200)
    `CHK("dead_time", 0, dt_err)
    end_of_test();
  end
endmodule // testbench
